// ---- hw/ptmr_params.svh ----
// register offsets, field positions, reset values and constants of the periodic timer
// assumes a 32-bit classic Wishbone slave; each 8-bit register sits in the low byte of a word
`ifndef PTMR_PARAMS_SVH
`define PTMR_PARAMS_SVH

`define PTMR_ADR_W        4
`define PTMR_ADR_SC       4'h0
`define PTMR_ADR_CLK      4'h4
`define PTMR_ADR_CNT      4'h8
`define PTMR_ADR_MOD      4'hc

`define PTMR_SC_TOF_BIT   7
`define PTMR_SC_OVERFLOW_IRQ_ENABLE_BIT  6
`define PTMR_SC_TRST_BIT  5
`define PTMR_SC_HALT_BIT  4
`define PTMR_CLK_CLOCK_SOURCE_SELECT_HI  5
`define PTMR_CLK_CLOCK_SOURCE_SELECT_LO  4
`define PTMR_CLK_PS_HI    3
`define PTMR_CLK_PS_LO    0

`define PTMR_CNT_RESET    8'h00
`define PTMR_MOD_RESET    8'h00
`define PTMR_PS_RESET     4'h0
`define PTMR_HALT_RESET   1'b1
`define PTMR_FREE_RUN     8'h00
`define PTMR_CNT_MAX      8'hff
`define PTMR_PS_MAXCODE   4'h8

`endif

// ---- hw/ptmr_pkg.sv ----
// types shared by the periodic timer and its prescaler
// assumes ptmr_params.svh sits on the include path
package ptmr_pkg;

  typedef enum logic [1:0] {
    PTMR_SRC_BUS,
    PTMR_SRC_FIXED,
    PTMR_SRC_EXT_FALL,
    PTMR_SRC_EXT_RISE
  } ptmr_clock_source_select_t;

  typedef struct packed {
    logic [7:0]  cnt;
    logic [7:0]  modv;
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic        halt;
    ptmr_clock_source_select_t  clock_source_select;
    logic [3:0]  ps;
    logic        armed;
    logic        ack;
    logic [31:0] rdat;
    logic        fixPrev;
    logic        extMeta;
    logic        extSync;
    logic        extPrev;
  } ptmr_state_t;

endpackage

// ---- hw/ptmr_presc_if.sv ----
// link between the timer core and its prescaler
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ptmr_presc_if;
  logic       tick;
  logic [3:0] ratioSel;
  logic       clear;
  logic       pulse;

  modport ctl   (output tick, output ratioSel, output clear, input pulse);
  modport presc (input tick, input ratioSel, input clear, output pulse);
endinterface
`default_nettype wire

// ---- hw/ptmr_prescaler.sv ----
// power-of-two prescaler of the periodic timer
// assumes ticks arrive as one-cycle enables on mclk
`timescale 1ns/1ps
`default_nettype none
module ptmr_prescaler
  import ptmr_pkg::*;
#(
  parameter int STAGES = 8
) (
  input  wire logic  mclk,
  input  wire logic  reset,
  ptmr_presc_if.presc pif
);

  if (STAGES < 1 || STAGES > 15) begin : g_chk
    $error("ptmr_prescaler: STAGES must lie in 1..15");
  end

  typedef struct packed {
    logic [STAGES-1:0] cnt;
  } ptmr_presc_state_t;

  ptmr_presc_state_t st_ff;
  ptmr_presc_state_t nxt_st;
  logic [STAGES:0]   fullMask;
  logic [STAGES-1:0] mask;
  logic [3:0]        n;

  // codes above the last ratio all divide by the largest one
  always_comb begin
    n        = (pif.ratioSel > 4'(STAGES)) ? 4'(STAGES) : pif.ratioSel;
    fullMask = ((STAGES+1)'(1) << n) - (STAGES+1)'(1);
    mask     = fullMask[STAGES-1:0];
  end

  assign pif.pulse = pif.tick && ((st_ff.cnt & mask) == mask);

  always_comb begin
    nxt_st = st_ff;
    if (pif.clear) begin
      nxt_st.cnt = '0;
    end else if (pif.tick) begin
      nxt_st.cnt = st_ff.cnt + STAGES'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  pulse_needs_tick_a: assert property (@(posedge mclk) disable iff (reset)
    pif.pulse |-> pif.tick) else $error("prescaler pulse without tick");
  div_one_a: assert property (@(posedge mclk) disable iff (reset)
    (pif.tick && pif.ratioSel == 4'h0) |-> pif.pulse) else $error("divide by one missed a tick");

endmodule
`default_nettype wire

// ---- hw/ptmr_timer.sv ----
// periodic timer: 8-bit up-counter with modulo limit, prescaler and Wishbone register slave
// assumes a classic Wishbone master on mclk and power-mode levels from the system controller
//
// Function
// - one 8-bit up-counter, free-running or limited by a modulo value.
// - overflow flag sets when the counter wraps from the limit to 0x00.
// - flag clears by reading status while set, then writing 0 to it.
// - counter-clear strobe or any modulo write also clears the flag.
// - interrupt request while enable and flag are both 1; reset clears enable.
// - writing 1 to the clear strobe zeroes counter and flag; strobe reads 0.
// - halt bit holds the count, clearing resumes; reset sets halt.
// - status bits 3 to 0 always read zero.
// - four count sources: bus, fixed-rate, pin rising, pin falling.
// - nine prescale ratios from 1 up to 256.
// - source codes 11 and 10 take the external count pin.
// - counting continues in wait mode; overflow interrupt can wake.
// - in stop mode the timer is disabled and never wakes anything.
// - deep stop exit or reset exit restores reset state; interrupt exit keeps it. Deep stop exit keeps the prescaler count, which reset or cntClear clears.
// - counter freezes in background debug and resumes unless cleared.
// - external count pin is synchronised to the bus clock.
// - four 8-bit registers: status, clock config, count, modulo.
// - source field 00 bus, 01 fixed, 10 pin falling, 11 pin rising; resets 00.
// - prescale codes 0 to 8 give 1 to 256, others 256; resets 0.
// - modulo 0x00 free-runs; modulo write zeroes count and flag; resets 0x00.
// - count register is read-only and reads 0x00 after reset.
//
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_params.svh"
module ptmr_timer
  import ptmr_pkg::*;
#(
  parameter int PRESC_STAGES = 8
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`PTMR_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  extCountClockIn,
  input  wire logic                  fixedRateClock,
  input  wire logic                  waitMode,
  input  wire logic                  stopMode,
  input  wire logic                  stopExitReset,
  input  wire logic                  bgdActive,
  output logic                       overflowIrq
);

  if (PRESC_STAGES != 8) begin : g_chk
    $error("ptmr_timer: the register map serves an 8-stage prescaler only");
  end

  ptmr_state_t st_ff;
  ptmr_state_t nxt_st;
  ptmr_state_t resetSt;

  logic       req;
  logic       acc;
  logic       wrLow;
  logic       scWrite;
  logic       clkWrite;
  logic       modWrite;
  logic       trstWrite;
  logic       tofClear;
  logic       cntClear;
  logic       running;
  logic       srcTick;
  logic       wrap;
  logic       tofSet;
  logic [7:0] wbByte;
  logic [7:0] rdByte;

  ptmr_presc_if pif ();

  ptmr_prescaler #(
    .STAGES (PRESC_STAGES)
  ) u_presc (
    .mclk  (mclk),
    .reset (reset),
    .pif   (pif)
  );

  always_comb begin
    resetSt      = '0;
    resetSt.cnt  = `PTMR_CNT_RESET;
    resetSt.modv = `PTMR_MOD_RESET;
    resetSt.halt = `PTMR_HALT_RESET;
    resetSt.clock_source_select = PTMR_SRC_BUS;
    resetSt.ps   = `PTMR_PS_RESET;
  end

  // bus decode; the write lands on the edge where the master sees ack
  assign req       = wb_cyc_i && wb_stb_i;
  assign acc       = req && st_ff.ack;
  assign wrLow     = acc && wb_we_i && wb_sel_i[0];
  assign wbByte    = wb_dat_i[7:0];
  assign scWrite   = wrLow && (wb_adr_i == `PTMR_ADR_SC);
  assign clkWrite  = wrLow && (wb_adr_i == `PTMR_ADR_CLK);
  assign modWrite  = wrLow && (wb_adr_i == `PTMR_ADR_MOD);
  assign trstWrite = scWrite && wbByte[`PTMR_SC_TRST_BIT];
  assign cntClear  = trstWrite || modWrite;
  // read-then-write-zero sequence; arming needs the flag seen set
  assign tofClear  = cntClear || (scWrite && st_ff.armed && !wbByte[`PTMR_SC_TOF_BIT]);

  // wait mode keeps counting, stop and debug freeze it
  assign running = !st_ff.halt && !stopMode && !bgdActive;

  always_comb begin
    case (st_ff.clock_source_select)
      PTMR_SRC_BUS:      srcTick = 1'b1;
      PTMR_SRC_FIXED:    srcTick = st_ff.fixPrev == 1'b0 && fixedRateClock;
      PTMR_SRC_EXT_FALL: srcTick = st_ff.extPrev && !st_ff.extSync;
      PTMR_SRC_EXT_RISE: srcTick = !st_ff.extPrev && st_ff.extSync;
      default:           srcTick = 1'b0;
    endcase
  end

  assign pif.tick     = running && srcTick && !cntClear;
  assign pif.ratioSel = st_ff.ps;
  assign pif.clear    = cntClear;

  // modulo 0x00 runs the full range
  assign wrap   = (st_ff.modv == `PTMR_FREE_RUN) ? (st_ff.cnt == `PTMR_CNT_MAX) : (st_ff.cnt == st_ff.modv);
  assign tofSet = pif.pulse && wrap;

  always_comb begin
    case (wb_adr_i)
      `PTMR_ADR_SC:  rdByte = {st_ff.overflow_flag, st_ff.overflow_irq_enable, 1'b0, st_ff.halt, 4'h0};
      `PTMR_ADR_CLK: rdByte = {2'b00, st_ff.clock_source_select, st_ff.ps};
      `PTMR_ADR_CNT: rdByte = st_ff.cnt;
      `PTMR_ADR_MOD: rdByte = st_ff.modv;
      default:       rdByte = 8'h00;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // synchroniser: only extSync looks at extMeta
    nxt_st.extMeta = extCountClockIn;
    nxt_st.extSync = st_ff.extMeta;
    nxt_st.extPrev = st_ff.extSync;
    nxt_st.fixPrev = fixedRateClock;

    nxt_st.ack  = req && !st_ff.ack;
    nxt_st.rdat = (req && !st_ff.ack) ? {24'h000000, rdByte} : st_ff.rdat;

    if (cntClear) begin
      nxt_st.cnt = `PTMR_CNT_RESET;
    end else if (pif.pulse) begin
      nxt_st.cnt = wrap ? 8'h00 : st_ff.cnt + 8'h01;
    end

    // an overflow in the clearing cycle is kept
    if (tofSet) begin
      nxt_st.overflow_flag = 1'b1;
    end else if (tofClear) begin
      nxt_st.overflow_flag = 1'b0;
    end

    if (acc && !wb_we_i && wb_adr_i == `PTMR_ADR_SC && st_ff.overflow_flag) begin
      nxt_st.armed = 1'b1;
    end else if (scWrite || !st_ff.overflow_flag) begin
      nxt_st.armed = 1'b0;
    end

    if (scWrite) begin
      nxt_st.overflow_irq_enable = wbByte[`PTMR_SC_OVERFLOW_IRQ_ENABLE_BIT];
      nxt_st.halt = wbByte[`PTMR_SC_HALT_BIT];
    end
    if (clkWrite) begin
      nxt_st.clock_source_select = ptmr_clock_source_select_t'(wbByte[`PTMR_CLK_CLOCK_SOURCE_SELECT_HI:`PTMR_CLK_CLOCK_SOURCE_SELECT_LO]);
      nxt_st.ps   = wbByte[`PTMR_CLK_PS_HI:`PTMR_CLK_PS_LO];
    end
    if (modWrite) begin
      nxt_st.modv = wbByte;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || stopExitReset) begin
      st_ff <= resetSt;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o    = st_ff.ack;
  assign wb_dat_o    = st_ff.rdat;
  // no request in stop so the timer never wakes from it
  assign overflowIrq = st_ff.overflow_flag && st_ff.overflow_irq_enable && !stopMode;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_after_req_a: assert property ((req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");
  wrap_sets_flag_a: assert property ((tofSet && !stopExitReset) |=> (st_ff.overflow_flag && st_ff.cnt == 8'h00))
    else $error("wrap did not set flag or zero count");
  step_by_one_a: assert property ((pif.pulse && !wrap && !stopExitReset) |=> st_ff.cnt == $past(st_ff.cnt) + 8'h01)
    else $error("counter did not step by one");
  strobe_clears_a: assert property ((trstWrite && !tofSet && !stopExitReset) |=> (st_ff.cnt == 8'h00 && !st_ff.overflow_flag))
    else $error("clear strobe left count or flag");
  mod_write_a: assert property ((modWrite && !stopExitReset) |=> (st_ff.modv == $past(wbByte) && st_ff.cnt == 8'h00))
    else $error("modulo write not applied");
  flag_clear_cause_a: assert property ((st_ff.overflow_flag && !stopExitReset) ##1 !st_ff.overflow_flag |-> $past(tofClear))
    else $error("flag fell without a clearing event");
  freeze_count_a: assert property ((!running && !cntClear && !stopExitReset) |=> st_ff.cnt == $past(st_ff.cnt))
    else $error("count moved while frozen");
  irq_tracks_a: assert property ((st_ff.overflow_flag && st_ff.overflow_irq_enable && !stopMode) |-> overflowIrq)
    else $error("interrupt missing");
  status_low_zero_a: assert property (($past(req && !wb_ack_o && wb_adr_i == `PTMR_ADR_SC)) |-> wb_dat_o[5:0] == 6'h00 || wb_dat_o[4] && wb_dat_o[3:0] == 4'h0 && !wb_dat_o[5])
    else $error("status reserved bits read nonzero");

  wrap_seen_c: cover property (tofSet);
  flag_cleared_c: cover property (st_ff.overflow_flag ##1 !st_ff.overflow_flag);
  ext_edge_c: cover property (pif.tick && st_ff.clock_source_select == PTMR_SRC_EXT_RISE);
  modulo_wrap_c: cover property (tofSet && st_ff.modv != 8'h00);

endmodule
`default_nettype wire

// ---- verification/ptmr_pin_source.sv ----
// behavioural far-side source for the external count pin and the fixed-rate clock
// assumes mclk is the timer's bus clock; both lines idle low between bursts
`timescale 1ns/1ps
`default_nettype none
module ptmr_pin_source (
  input  wire logic mclk,
  output var logic  extPin,
  output var logic  fixedClk
);
  initial begin
    extPin   = 1'b0;
    fixedClk = 1'b0;
  end
  // eight-cycle period leaves margin under the quarter-rate ceiling
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge mclk);
      extPin   <= 1'b1;
      fixedClk <= 1'b1;
      repeat (4) @(posedge mclk);
      extPin   <= 1'b0;
      fixedClk <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- verification/modulo_timer_8bit_bench.sv ----
// self-checking bench of the periodic timer against an integer model
// assumes ptmr_pkg and ptmr_params.svh are compiled ahead of this file
`timescale 1ns/1ps
`default_nettype none
`include "ptmr_params.svh"
module modulo_timer_8bit_bench;
  logic        mclk, reset, cyc, stb, we, extPin, fixedClk, waitMode, stopMode, stopExit, bgd, irq, ack;
  logic [3:0]  adr, sel, ps;
  logic [1:0]  src;
  logic [31:0] datI, datO, rd, rd2;
  logic        mFlag;
  int          miscompares = 0, nChecks = 0, cycles = 0, seed = 14, mCnt, mMod, mPre, mDiv, k;
  logic [3:0]  adrTab [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
  logic [31:0] rstTab [5] = '{32'h10, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [3:0]  psTab [6]  = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'hf};

  ptmr_timer #(.PRESC_STAGES(8)) i_ptmr_timer (
    .mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .extCountClockIn(extPin),
    .fixedRateClock(fixedClk), .waitMode(waitMode), .stopMode(stopMode), .stopExitReset(stopExit),
    .bgdActive(bgd), .overflowIrq(irq));
  ptmr_pin_source i_ptmr_pin_source (.mclk(mclk), .extPin(extPin), .fixedClk(fixedClk));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // worst case loop is about six thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    datI <= {24'h0, d};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 20) begin
      miscompares++;
      summarize();
    end
  endtask

  task automatic mdlRun(input int n);
    mPre += n;
    repeat (mPre / mDiv) begin
      if (mCnt == ((mMod == 0) ? 255 : mMod)) begin
        mCnt  = 0;
        mFlag = 1'b1;
      end else begin
        mCnt++;
      end
    end
    mPre = mPre % mDiv;
  endtask

  initial begin
    reset = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'hf; datI = 32'h0;
    waitMode = 1'b0; stopMode = 1'b0; stopExit = 1'b0; bgd = 1'b0;
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, adrTab[i], 8'h00);
      chk("resetValue", rd, rstTab[i]);
    end
    wb(1'b1, `PTMR_ADR_CNT, 8'h55);
    wb(1'b0, `PTMR_ADR_CNT, 8'h00);
    chk("countReadOnly", rd, 32'h0);
    // a write without the low byte lane must leave the modulo value alone
    sel <= 4'he;
    wb(1'b1, `PTMR_ADR_MOD, 8'h33);
    sel <= 4'hf;
    wb(1'b0, `PTMR_ADR_MOD, 8'h00);
    chk("laneIgnored", rd, 32'h0);
    for (int i = 0; i < 6; i++) begin
      ps   = psTab[i];
      src  = 2'(1 + i % 3);
      mDiv = (ps > 4'h8) ? 256 : (1 << ps);
      k    = (mDiv > 8) ? 1 : 1 + ($unsigned($random(seed)) % 12);
      mMod = 1 + ($unsigned($random(seed)) % 7);
      wb(1'b1, `PTMR_ADR_CLK, {2'b00, src, ps});
      wb(1'b1, `PTMR_ADR_MOD, 8'(mMod));
      mCnt = 0; mFlag = 1'b0; mPre = 0;
      wb(1'b1, `PTMR_ADR_SC, 8'h00);
      i_ptmr_pin_source.burst(k * mDiv);
      mdlRun(k * mDiv);
      repeat (6) @(posedge mclk);
      wb(1'b1, `PTMR_ADR_SC, 8'h00);
      wb(1'b0, `PTMR_ADR_CNT, 8'h00);
      chk("count", rd, 32'(mCnt));
      wb(1'b0, `PTMR_ADR_SC, 8'h00);
      chk("flagKept", rd, {24'h0, mFlag, 7'h00});
      wb(1'b1, `PTMR_ADR_SC, 8'h00);
      wb(1'b0, `PTMR_ADR_SC, 8'h00);
      chk("flagCleared", rd, 32'h0);
    end
    wb(1'b1, `PTMR_ADR_CLK, 8'h30);
    wb(1'b1, `PTMR_ADR_MOD, 8'h02);
    // enable set while the flag is still clear
    wb(1'b1, `PTMR_ADR_SC, 8'h40);
    i_ptmr_pin_source.burst(3);
    repeat (6) @(posedge mclk);
    wb(1'b0, `PTMR_ADR_SC, 8'h00);
    chk("flagWithEnable", rd, 32'hc0);
    @(negedge mclk);
    chk("irqRaised", {31'h0, irq}, 32'h1);
    @(posedge mclk);
    stopMode <= 1'b1;
    @(negedge mclk);
    chk("irqInStop", {31'h0, irq}, 32'h0);
    i_ptmr_pin_source.burst(2);
    stopMode <= 1'b0;
    bgd      <= 1'b1;
    i_ptmr_pin_source.burst(2);
    repeat (6) @(posedge mclk);
    bgd      <= 1'b0;
    waitMode <= 1'b1;
    i_ptmr_pin_source.burst(1);
    repeat (6) @(posedge mclk);
    waitMode <= 1'b0;
    wb(1'b0, `PTMR_ADR_CNT, 8'h00);
    chk("frozenThenWait", rd, 32'h1);
    wb(1'b1, `PTMR_ADR_SC, 8'h60);
    wb(1'b0, `PTMR_ADR_SC, 8'h00);
    chk("strobeStatus", rd, 32'h40);
    wb(1'b0, `PTMR_ADR_CNT, 8'h00);
    chk("strobeCount", rd, 32'h0);
    wb(1'b1, `PTMR_ADR_SC, 8'h10);
    i_ptmr_pin_source.burst(2);
    repeat (6) @(posedge mclk);
    wb(1'b0, `PTMR_ADR_CNT, 8'h00);
    chk("halted", rd, 32'h0);
    wb(1'b1, `PTMR_ADR_CLK, 8'h00);
    wb(1'b1, `PTMR_ADR_MOD, 8'h00);
    wb(1'b1, `PTMR_ADR_SC, 8'h00);
    wb(1'b0, `PTMR_ADR_CNT, 8'h00);
    rd2 = rd;
    wb(1'b0, `PTMR_ADR_CNT, 8'h00);
    chk("busSource", {31'h0, rd !== rd2}, 32'h1);
    @(posedge mclk);
    stopExit <= 1'b1;
    @(posedge mclk);
    stopExit <= 1'b0;
    wb(1'b0, `PTMR_ADR_SC, 8'h00);
    chk("exitStatus", rd, 32'h10);
    wb(1'b0, `PTMR_ADR_CNT, 8'h00);
    chk("exitCount", rd, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
